// ---- hw/break_and_monitor_debug.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Address bus equal to break address on an opcode fetch raises break request.
// - Break request substitutes soft interrupt opcode for fetched opcode.
// - Break vector FFFC normally, FEFC while monitor active.
// - Break only from program-counter match or software break-active write.
// - Return-from-interrupt inside break routine ends break.
// - During break, hold off watchdog and keep I/O registers reachable.
// - Monitor echoes every received byte except a break character on the serial pin.
// - Wait 11 bit times before executing; host break cancels.
// - Two bit times before each echo and each read data byte.
// - Read data is sent only after the final byte's echo.
// - Read command 4A, address high then low, returns memory byte.
// - Indexed reads and writes step through consecutive addresses.
module break_and_monitor_debug #(
	parameter int BIT_CYCLES = dbg_pkg::BIT_CYCLES
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// CPU bus observation
	input  wire logic [15:0] addr_bus,
	input  wire logic        opcode_fetch,
	input  wire logic [7:0]  fetched_opcode,
	input  wire logic        rti_exec,
	input  wire logic        monitor_active,
	// Break control from software
	input  wire logic [15:0] break_addr_wdata,
	input  wire logic        break_addr_we,
	input  wire logic        break_enable,
	input  wire logic        break_active_bit_set,
	// Break outputs toward CPU and system logic
	output logic             break_request,
	output logic [7:0]       instr_reg_data,
	output logic [15:0]      break_vector,
	output logic             break_in_progress,
	output logic             watchdog_hold,
	output logic             io_access_enable,
	// Monitor memory port
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_we,
	output logic             mem_re,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic [15:0] stack_pointer,
	// Monitor serial pin, output enable low while driving
	input  wire logic        monitor_serial_pin_i,
	output logic             monitor_serial_pin_o,
	output logic             monitor_serial_pin_oe_n,
	output logic             cmd_cancelled
);
	typedef enum logic [2:0] {M_OP, M_AH, M_AL, M_DATA, M_WAIT, M_EXEC} mon_state_t;
	// Counter width and compare points, sized so no compare mixes widths
	localparam int               CNT_W    = $clog2(BIT_CYCLES + 1);
	localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(BIT_CYCLES / 2);

	logic [15:0] break_addr_ff;
	logic        in_break_ff;
	logic        pend_ff;
	logic [$clog2(BIT_CYCLES+1)-1:0] bit_cnt_ff;
	logic        bit_tick;
	// Receiver
	logic [3:0]  rx_bit_ff;
	logic [9:0]  rx_sh_ff;
	logic        rx_busy_ff;
	logic [$clog2(BIT_CYCLES+1)-1:0] rx_cnt_ff;
	logic        rx_done;
	logic [7:0]  rx_byte;
	logic        rx_break;
	// Command engine
	mon_state_t  st_ff;
	logic [7:0]  op_ff;
	logic [15:0] idx_ff;
	logic [7:0]  wd_ff;
	logic [3:0]  wait_ff;
	logic        rd_ff;
	// Transmit path
	logic        q_valid;
	logic        q_ready;
	logic [7:0]  q_data;
	logic        tx_valid;
	logic        tx_ready;
	logic [7:0]  tx_data;
	logic [9:0]  tx_sh_ff;
	logic [3:0]  tx_bit_ff;
	logic [3:0]  tx_gap_ff;
	logic        tx_busy_ff;

	// Break address register, loaded by software
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			break_addr_ff <= dbg_pkg::BREAK_ADDR_RST;
		else if (break_addr_we)
			break_addr_ff <= break_addr_wdata;
	end

	// Match only on opcode fetches so data accesses cannot trigger
	assign break_request = (break_enable && opcode_fetch && addr_bus == break_addr_ff)
		|| break_active_bit_set || pend_ff;

	// Break state: set wins over end of break
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			in_break_ff <= 1'b0;
			pend_ff     <= 1'b0;
		end else begin
			if (break_active_bit_set && !opcode_fetch)
				pend_ff <= 1'b1; // Held until the next fetch takes it
			else if (opcode_fetch)
				pend_ff <= 1'b0;
			if (break_request && opcode_fetch)
				in_break_ff <= 1'b1;
			else if (rti_exec)
				in_break_ff <= 1'b0;
		end
	end

	assign instr_reg_data   = (break_request && opcode_fetch) ? dbg_pkg::SOFT_INT_OPCODE : fetched_opcode;
	assign break_vector     = monitor_active ? dbg_pkg::VEC_MONITOR : dbg_pkg::VEC_NORMAL;
	assign break_in_progress = in_break_ff;
	assign watchdog_hold    = in_break_ff;
	assign io_access_enable = 1'b1;

	// Bit-time divider; enable pulse once per bit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			bit_cnt_ff <= '0;
		else if (bit_tick)
			bit_cnt_ff <= '0;
		else
			bit_cnt_ff <= bit_cnt_ff + 1'b1;
	end
	assign bit_tick = (bit_cnt_ff == BIT_LAST);

	// Receiver samples mid-bit; ignores the line while we transmit
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rx_busy_ff <= 1'b0;
			rx_bit_ff  <= 4'h0;
			rx_sh_ff   <= '0;
			rx_cnt_ff  <= '0;
		end else if (!rx_busy_ff) begin
			if (!monitor_serial_pin_i && !tx_busy_ff) begin
				rx_busy_ff <= 1'b1;
				rx_cnt_ff  <= '0;
				rx_bit_ff  <= 4'h0;
			end
		end else if (rx_cnt_ff == BIT_HALF) begin
			rx_sh_ff  <= {monitor_serial_pin_i, rx_sh_ff[9:1]};
			rx_bit_ff <= rx_bit_ff + 4'h1;
			rx_cnt_ff <= rx_cnt_ff + 1'b1;
			if (rx_bit_ff == dbg_pkg::FRAME_BITS - 4'h1 || (rx_bit_ff == 4'h0 && monitor_serial_pin_i))
				rx_busy_ff <= 1'b0; // Also drops a false start, such as the tail of a break
		end else if (rx_cnt_ff == BIT_LAST)
			rx_cnt_ff <= '0;
		else
			rx_cnt_ff <= rx_cnt_ff + 1'b1;
	end
	assign rx_done  = rx_busy_ff && rx_cnt_ff == BIT_HALF && rx_bit_ff == dbg_pkg::FRAME_BITS - 4'h1;
	assign rx_byte  = rx_sh_ff[9:2];
	// Break character: all zero including the stop bit
	assign rx_break = rx_done && !monitor_serial_pin_i && rx_sh_ff[9:2] == 8'h00;

	// Command engine
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_ff         <= M_OP;
			op_ff         <= 8'h00;
			idx_ff        <= dbg_pkg::INDEX_RST;
			wd_ff         <= 8'h00;
			wait_ff       <= 4'h0;
			rd_ff         <= 1'b0;
			cmd_cancelled <= 1'b0;
			mem_we        <= 1'b0;
			mem_re        <= 1'b0;
		end else begin
			cmd_cancelled <= 1'b0;
			mem_we        <= 1'b0;
			mem_re        <= 1'b0;
			rd_ff         <= mem_re || (rd_ff && !q_ready); // Hold read data until the buffer takes it
			case (st_ff)
				M_OP: if (rx_done && !rx_break) begin
					op_ff <= rx_byte;
					if (rx_byte == dbg_pkg::CMD_READ || rx_byte == dbg_pkg::CMD_WRITE)
						st_ff <= M_AH;
					else if (rx_byte == dbg_pkg::CMD_INDEXED_WRITE_CMD)
						st_ff <= M_DATA;
					else if (rx_byte == dbg_pkg::CMD_INDEXED_READ_CMD || rx_byte == dbg_pkg::CMD_SPREAD) begin
						st_ff   <= M_WAIT;
						wait_ff <= dbg_pkg::EXEC_DELAY_BITS;
					end
				end
				M_AH: if (rx_done) begin
					idx_ff[15:8] <= rx_byte;
					st_ff        <= M_AL;
				end
				M_AL: if (rx_done) begin
					idx_ff[7:0] <= rx_byte;
					if (op_ff == dbg_pkg::CMD_WRITE)
						st_ff <= M_DATA;
					else begin
						st_ff   <= M_WAIT;
						wait_ff <= dbg_pkg::EXEC_DELAY_BITS;
					end
				end
				M_DATA: if (rx_done) begin
					wd_ff   <= rx_byte;
					st_ff   <= M_WAIT;
					wait_ff <= dbg_pkg::EXEC_DELAY_BITS;
				end
				M_WAIT: begin
					if (rx_break) begin
						st_ff         <= M_OP;
						cmd_cancelled <= 1'b1;
					end else if (rx_busy_ff || tx_busy_ff || q_valid)
						wait_ff <= dbg_pkg::EXEC_DELAY_BITS; // Count from the last echo's end
					else if (bit_tick) begin
						if (wait_ff == 4'h1)
							st_ff <= M_EXEC;
						wait_ff <= wait_ff - 4'h1;
					end
				end
				M_EXEC: begin
					st_ff <= M_OP;
					if (op_ff == dbg_pkg::CMD_WRITE || op_ff == dbg_pkg::CMD_INDEXED_WRITE_CMD)
						mem_we <= 1'b1;
					else if (op_ff != dbg_pkg::CMD_SPREAD)
						mem_re <= 1'b1;
				end
				default: st_ff <= M_OP;
			endcase
			// Index steps only after the access has used it, so the strobe sees the old address
			if ((mem_we && op_ff == dbg_pkg::CMD_INDEXED_WRITE_CMD) || (rd_ff && q_ready && op_ff == dbg_pkg::CMD_INDEXED_READ_CMD))
				idx_ff <= idx_ff + 16'h0001;
		end
	end

	// Memory address and write data from flip-flops
	assign mem_addr  = idx_ff;
	assign mem_wdata = wd_ff;

	// Echo each byte except a break character, then the read data; buffer absorbs transmitter stalls
	assign q_valid = (rx_done && !rx_break) || rd_ff
		|| (st_ff == M_EXEC && op_ff == dbg_pkg::CMD_SPREAD);
	assign q_data  = rx_done ? rx_byte : (rd_ff ? mem_rdata : stack_pointer[7:0]);

	dbg_buf2 #(.WIDTH(8)) dbg_buf2_i (
		.mclk      (mclk),
		.rstn      (rstn),
		.in_valid  (q_valid),
		.in_ready  (q_ready),
		.in_data   (q_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	// Transmitter waits two bit times before each byte, as turnaround
	assign tx_ready = !tx_busy_ff && tx_gap_ff == dbg_pkg::ECHO_DELAY_BITS && bit_tick;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_busy_ff <= 1'b0;
			tx_sh_ff   <= 10'h3ff;
			tx_bit_ff  <= 4'h0;
			tx_gap_ff  <= 4'h0;
		end else if (tx_ready && tx_valid) begin
			tx_busy_ff <= 1'b1;
			tx_sh_ff   <= {1'b1, tx_data, 1'b0};
			tx_bit_ff  <= 4'h0;
			tx_gap_ff  <= 4'h0;
		end else if (bit_tick) begin
			if (tx_busy_ff) begin
				tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
				tx_bit_ff <= tx_bit_ff + 4'h1;
				if (tx_bit_ff == dbg_pkg::FRAME_BITS - 4'h1)
					tx_busy_ff <= 1'b0;
			end else if (!tx_valid)
				tx_gap_ff <= 4'h0;
			else if (tx_gap_ff != dbg_pkg::ECHO_DELAY_BITS)
				tx_gap_ff <= tx_gap_ff + 4'h1;
		end
	end
	assign monitor_serial_pin_o    = tx_sh_ff[0];
	assign monitor_serial_pin_oe_n = !tx_busy_ff;
endmodule // break_and_monitor_debug

// ---- hw/dbg_pkg.sv ----
package dbg_pkg;
	// Vector locations for break entry
	localparam logic [15:0] VEC_NORMAL  = 16'hfffc;
	localparam logic [15:0] VEC_MONITOR = 16'hfefc;
	// Opcodes
	localparam logic [7:0]  SOFT_INT_OPCODE = 8'h83;
	localparam logic [7:0]  CMD_READ        = 8'h4a;
	localparam logic [7:0]  CMD_WRITE       = 8'h49;
	localparam logic [7:0]  CMD_INDEXED_READ_CMD       = 8'h1a;
	localparam logic [7:0]  CMD_INDEXED_WRITE_CMD      = 8'h19;
	localparam logic [7:0]  CMD_SPREAD      = 8'h0c;
	// Serial timing
	localparam int          MCLK_HZ        = 100_000_000;
	localparam int          BAUD_HZ        = 9600;
	localparam int          BIT_CYCLES     = MCLK_HZ / BAUD_HZ;
	localparam logic [3:0]  EXEC_DELAY_BITS = 4'hb;
	localparam logic [3:0]  ECHO_DELAY_BITS = 4'h2;
	localparam logic [3:0]  FRAME_BITS      = 4'ha;
	// Reset values
	localparam logic [15:0] BREAK_ADDR_RST = 16'hffff;
	localparam logic [15:0] INDEX_RST      = 16'h0000;
endpackage

// ---- hw/dbg_buf2.sv ----
`timescale 1ns/1ps
// Two-entry skid buffer so a stalled transmitter loses no byte
module dbg_buf2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rstn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] mem_ff [2];
	logic             rd_ff;
	logic             wr_ff;
	logic [1:0]       cnt_ff;
	logic             push;
	logic             pop;

	// Handshake terms are combinational from the count
	assign in_ready  = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage and pointers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
			rd_ff     <= 1'b0;
			wr_ff     <= 1'b0;
			cnt_ff    <= 2'h0;
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= in_data;
				wr_ff         <= ~wr_ff;
			end
			if (pop)
				rd_ff <= ~rd_ff;
			if (push && !pop)
				cnt_ff <= cnt_ff + 2'h1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end
endmodule // dbg_buf2

// ---- test/dbg_host.sv ----
`timescale 1ns/1ps
// Host on the monitor wire; the line is pulled high when nobody drives
module dbg_host #(
	parameter int BIT = 16
) (
	// Clock
	input wire logic mclk,
	// Device side of the wire
	input wire logic dev_o,
	input wire logic dev_oe_n,
	output logic     line
);
	logic tx = 1'b1;
	// Device wins while its enable is low
	assign line = dev_oe_n ? tx : dev_o;
	// One frame; a low stop with zero data makes a break character
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk) tx = f[i];
			repeat (BIT - 1) @(negedge mclk);
		end
		@(negedge mclk) tx = 1'b1;
	endtask
	// Receive one frame, sampling mid-bit; ok carries the stop level
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (line !== 1'b0 && n < 80 * BIT) begin
			@(negedge mclk);
			n++;
		end
		if (n < 80 * BIT) begin
			repeat (BIT / 2) @(negedge mclk);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT) @(negedge mclk);
				if (i < 8) b[i] = line;
				else ok = line;
			end
			// Stay quiet one bit past the stop bit
			repeat (BIT + BIT / 2) @(negedge mclk);
		end
	endtask
endmodule // dbg_host

// ---- test/break_and_monitor_debug_asserts.sv ----
`timescale 1ns/1ps
// Break path and strobe checks on the top ports
module break_and_monitor_debug_asserts (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Watched ports
	input wire logic [7:0] fetched_opcode,
	input wire logic opcode_fetch,
	input wire logic rti_exec,
	input wire logic monitor_active,
	input wire logic break_active_bit_set,
	input wire logic break_request,
	input wire logic [7:0] instr_reg_data,
	input wire logic [15:0] break_vector,
	input wire logic break_in_progress,
	input wire logic watchdog_hold,
	input wire logic io_access_enable,
	input wire logic mem_re
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_soft_request: assert property (break_active_bit_set |-> break_request)
		else $error("soft set lost");
	a_opcode_swap: assert property (break_request && opcode_fetch |-> instr_reg_data == 8'h83)
		else $error("no swap");
	a_opcode_pass: assert property (!break_request |-> instr_reg_data == fetched_opcode)
		else $error("bad pass");
	a_vector_pick: assert property (break_vector == (monitor_active ? 16'hfefc : 16'hfffc))
		else $error("bad vector");
	a_break_entry: assert property (break_request && opcode_fetch |=> break_in_progress)
		else $error("no entry");
	a_rti_ends: assert property (rti_exec && !break_request |=> !break_in_progress)
		else $error("rti kept break");
	a_wdog_hold: assert property (break_in_progress |-> watchdog_hold)
		else $error("watchdog free");
	a_io_reach: assert property (break_in_progress |-> io_access_enable)
		else $error("io blocked");
	a_read_pulse: assert property ($rose(mem_re) |=> !mem_re)
		else $error("long strobe");
endmodule // break_and_monitor_debug_asserts

bind break_and_monitor_debug break_and_monitor_debug_asserts break_and_monitor_debug_asserts_i (
	.mclk, .rstn, .fetched_opcode, .opcode_fetch, .rti_exec, .monitor_active, .break_active_bit_set,
	.break_request, .instr_reg_data, .break_vector, .break_in_progress, .watchdog_hold, .io_access_enable,
	.mem_re);

// ---- test/break_and_monitor_debug_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, v); end end
// Drives the CPU side and the host wire
module break_and_monitor_debug_bench;
	localparam int BIT = 16;
	logic mclk = 1'b0, rstn = 1'b0, opcode_fetch = 1'b0, rti_exec = 1'b0, monitor_active = 1'b0;
	logic break_addr_we = 1'b0, break_enable = 1'b0, break_active_bit_set = 1'b0;
	logic [15:0] addr_bus = 16'h0000, break_addr_wdata = 16'h0000, stack_pointer = 16'h00ff;
	logic [7:0] fetched_opcode = 8'h9d, mem_rdata = 8'h00, instr_reg_data, mem_wdata;
	logic break_request, break_in_progress, watchdog_hold, mem_we, mem_re, pin_o, pin_oe_n, line, cmd_cancelled;
	logic [15:0] break_vector, mem_addr, re_addr;
	logic io_en;
	logic [15:0] we_addr[$];
	logic [7:0] we_data[$];
	int err_total = 0, checked = 0, cyc = 0, re_cnt = 0, cc_cnt = 0;
	break_and_monitor_debug #(.BIT_CYCLES(BIT)) break_and_monitor_debug_i (
		.mclk, .rstn, .addr_bus, .opcode_fetch, .fetched_opcode, .rti_exec, .monitor_active,
		.break_addr_wdata, .break_addr_we, .break_enable, .break_active_bit_set, .break_request,
		.instr_reg_data, .break_vector, .break_in_progress, .watchdog_hold, .io_access_enable(io_en),
		.mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata, .stack_pointer,
		.monitor_serial_pin_i(line), .monitor_serial_pin_o(pin_o), .monitor_serial_pin_oe_n(pin_oe_n),
		.cmd_cancelled);
	dbg_host #(.BIT(BIT)) dbg_host_i (.mclk, .dev_o(pin_o), .dev_oe_n(pin_oe_n), .line);
	always #5 mclk = ~mclk;
	// Memory answers with a pattern of its address
	always @(negedge mclk) mem_rdata <= mem_addr[7:0] ^ 8'h5a;
	// Strobe log and hang guard; the run needs well under 20000 cycles
	always @(posedge mclk) begin
		cyc++;
		if (mem_re === 1'b1) begin
			re_cnt++;
			re_addr = mem_addr;
		end
		if (cmd_cancelled === 1'b1) cc_cnt++;
		if (mem_we === 1'b1) begin
			we_addr.push_back(mem_addr);
			we_data.push_back(mem_wdata);
		end
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Address match, soft set, rti and vectors
	task automatic t_break();
		@(negedge mclk);
		break_addr_wdata = 16'h0123;
		break_addr_we = 1'b1;
		break_enable = 1'b1;
		@(negedge mclk);
		break_addr_we = 1'b0;
		addr_bus = 16'h0122;
		opcode_fetch = 1'b1;
		#1 `CHK("near miss", 1'b0, break_request)
		@(negedge mclk);
		addr_bus = 16'h0123;
		#1 `CHK("match", 1'b1, break_request)
		`CHK("opcode", dbg_pkg::SOFT_INT_OPCODE, instr_reg_data)
		`CHK("vector n", dbg_pkg::VEC_NORMAL, break_vector)
		@(negedge mclk);
		opcode_fetch = 1'b0;
		`CHK("hold", 1'b1, watchdog_hold)
		`CHK("io reach", 1'b1, io_en)
		rti_exec = 1'b1;
		@(negedge mclk);
		rti_exec = 1'b0;
		break_enable = 1'b0;
		`CHK("after rti", 1'b0, break_in_progress)
		break_active_bit_set = 1'b1;
		#1 `CHK("soft req", 1'b1, break_request)
		@(negedge mclk);
		break_active_bit_set = 1'b0;
		opcode_fetch = 1'b1;
		@(negedge mclk);
		opcode_fetch = 1'b0;
		monitor_active = 1'b1;
		#1 `CHK("soft break", 1'b1, break_in_progress)
		`CHK("vector", dbg_pkg::VEC_MONITOR, break_vector)
		rti_exec = 1'b1;
		@(negedge mclk);
		rti_exec = 1'b0;
	endtask
	// One byte out, its echo back
	task automatic xfer(input logic [7:0] b);
		logic [7:0] e;
		logic ok;
		dbg_host_i.send(b, 1'b1);
		dbg_host_i.recv(e, ok);
		`CHK("echo", b, e)
		`CHK("stop", 1'b1, ok)
	endtask
	// Expect a returned data byte
	task automatic rd(input logic [7:0] x);
		logic [7:0] d;
		logic ok;
		dbg_host_i.recv(d, ok);
		`CHK("data", x, d)
	endtask
	// Memory read, then a read cancelled by a break character
	task automatic t_read();
		xfer(dbg_pkg::CMD_READ);
		xfer(8'h12);
		xfer(8'h34);
		`CHK("early", 0, re_cnt)
		rd(8'h34 ^ 8'h5a);
		`CHK("addr", 16'h1234, re_addr)
		xfer(dbg_pkg::CMD_READ);
		xfer(8'h00);
		xfer(8'h40);
		dbg_host_i.send(8'h00, 1'b0);
		repeat (30 * BIT) @(negedge mclk);
		`CHK("cancel", 1, cc_cnt)
		`CHK("no read", 1, re_cnt)
	endtask
	// Plain write sets the index, indexed writes step from it, indexed read follows, stack read
	task automatic t_index();
		xfer(dbg_pkg::CMD_WRITE);
		xfer(8'h00);
		xfer(8'h80);
		xfer(8'h3c);
		repeat (14 * BIT) @(negedge mclk);
		for (int i = 0; i < 2; i++) begin
			xfer(dbg_pkg::CMD_INDEXED_WRITE_CMD);
			xfer(8'ha5 + 8'(i));
			repeat (14 * BIT) @(negedge mclk);
		end
		`CHK("writes", 3, we_addr.size())
		`CHK("waddr", 16'h0080, we_addr[0])
		`CHK("wbyte", 8'h3c, we_data[0])
		`CHK("first step", 16'h0080, we_addr[1])
		`CHK("step", 16'h0081, we_addr[2])
		`CHK("wdata", 8'ha6, we_data[2])
		xfer(dbg_pkg::CMD_INDEXED_READ_CMD);
		rd(8'h82 ^ 8'h5a);
		`CHK("indexed_read_cmd addr", 16'h0082, re_addr)
		xfer(dbg_pkg::CMD_SPREAD);
		rd(8'hff);
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		`CHK("idle pin", 1'b1, pin_o)
		`CHK("pin off", 1'b1, pin_oe_n)
		rstn = 1'b1;
		t_break();
		t_read();
		t_index();
		tally_and_finish();
	end
endmodule // break_and_monitor_debug_bench
